// ===== hw/pc_stack_pkg.sv
// Constants and state types for the program counter, return stack and indirect addressing
`default_nettype none
package pc_stack_pkg;

    localparam int PC_W = 13;
    localparam int LATCH_W = 5;
    localparam int TARGET_W = 11;
    localparam int FILE_ADDR_W = 9;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;
    localparam int WB_DAT_W = 32;
    localparam int WB_ADR_W = 8;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_PC_LOW_BYTE = 8'h00;
    localparam logic [7:0] OFS_PC_UPPER_LATCH = 8'h04;
    localparam logic [7:0] OFS_FILE_POINTER = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_INDIRECT_DATA_PORT = 8'h10;

    // Control register field positions
    localparam int CTRL_BANK_BIT = 0;
    localparam int CTRL_SMALL_MEM_BIT = 1;

    // Page-select bit positions within the upper latch
    localparam int LATCH_PAGE_HI = 4;
    localparam int LATCH_PAGE_LO = 3;

    // Values after reset, and the interrupt vector
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
    localparam logic [7:0] FILE_POINTER_RESET = 8'h00;
    localparam logic STACK_PTR_RESET_BIT = 1'b0;
    localparam logic [STACK_PTR_W-1:0] STACK_PTR_RESET = 3'h0;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

    typedef enum {
        BUS_IDLE,
        BUS_FILE_WAIT,
        BUS_FILE_TAKE
    } bus_state_t;

    typedef struct packed {
        logic [STACK_DEPTH-1:0][PC_W-1:0] slot;
        logic [STACK_PTR_W-1:0] ptr;
    } stack_state_t;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [LATCH_W-1:0] latch;
        logic [7:0] fptr;
        logic bank;
        logic small_mem;
        logic ack;
        logic [WB_DAT_W-1:0] dat;
        logic [FILE_ADDR_W-1:0] file_addr;
        logic file_re;
        logic file_we;
        logic [7:0] file_wdata;
        logic [FILE_ADDR_W-1:0] ind_addr;
        logic ind_null;
        bus_state_t bus;
    } core_state_t;

    // Upper five counter bits for a low-byte write
    function automatic logic [LATCH_W-1:0] upper_from_latch(input logic [LATCH_W-1:0] latch,
                                                            input logic small_mem);
        upper_from_latch = {latch[LATCH_PAGE_HI] & ~small_mem, latch[LATCH_W-2:0]};
    endfunction

    // Full target for a call or jump
    function automatic logic [PC_W-1:0] branch_target(input logic [LATCH_W-1:0] latch,
                                                      input logic small_mem,
                                                      input logic [TARGET_W-1:0] target);
        branch_target = {latch[LATCH_PAGE_HI] & ~small_mem, latch[LATCH_PAGE_LO], target};
    endfunction

endpackage
`default_nettype wire

// ===== hw/return_stack.sv
// Eight-entry circular return stack of counter values
`default_nettype none
`timescale 1ns/10ps
module return_stack (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [pc_stack_pkg::PC_W-1:0] push_data_i,
    output logic [pc_stack_pkg::PC_W-1:0] top_o
);
    import pc_stack_pkg::*;

    // Slots live outside program and data space; the pointer has no bus path
    stack_state_t st_q;
    stack_state_t st_d;

    // Entry that a pop would return
    assign top_o = st_q.slot[st_q.ptr - 3'h1];

    always_comb begin
        st_d = st_q;
        if (push_i) begin
            // Pointer wraps, ninth push lands on the first slot; no overflow flag exists
            st_d.slot[st_q.ptr] = push_data_i;
            st_d.ptr = st_q.ptr + 3'h1;
        end else if (pop_i) begin
            st_d.ptr = st_q.ptr - 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q.ptr <= STACK_PTR_RESET;
            st_q.slot <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule // return_stack
`default_nettype wire

// ===== hw/indirect_addr.sv
// Forms the indirect data address and its null-pointer flag
`default_nettype none
`timescale 1ns/10ps
module indirect_addr (
    input wire logic [7:0] file_pointer_i,
    input wire logic indirect_bank_bit_i,
    output logic [pc_stack_pkg::FILE_ADDR_W-1:0] addr_o,
    output logic null_o
);
    import pc_stack_pkg::*;

    assign addr_o = {indirect_bank_bit_i, file_pointer_i};
    assign null_o = (file_pointer_i == FILE_POINTER_RESET);

endmodule // indirect_addr
`default_nettype wire

// ===== hw/program_counter_stack_indirect.sv
// Program counter, return stack, page select and indirect addressing with a Wishbone slave
`default_nettype none
`timescale 1ns/10ps
module program_counter_stack_indirect (
    input wire logic clk_i,
    input wire logic rst_i,
    // Instruction sequencer
    input wire logic fetch_i,
    input wire logic call_i,
    input wire logic jump_i,
    input wire logic return_i,
    input wire logic irq_vector_i,
    input wire logic [pc_stack_pkg::TARGET_W-1:0] target_i,
    input wire logic pcl_write_i,
    input wire logic [7:0] pcl_wdata_i,
    output logic [pc_stack_pkg::PC_W-1:0] program_counter_o,
    output logic [pc_stack_pkg::FILE_ADDR_W-1:0] indirect_addr_o,
    output logic indirect_null_o,
    // Data register file
    output logic [pc_stack_pkg::FILE_ADDR_W-1:0] file_addr_o,
    output logic file_re_o,
    output logic file_we_o,
    output logic [7:0] file_wdata_o,
    input wire logic [7:0] file_rdata_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pc_stack_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [pc_stack_pkg::WB_DAT_W-1:0] wb_dat_i,
    output logic [pc_stack_pkg::WB_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o
);
    import pc_stack_pkg::*;

    core_state_t s_q;
    core_state_t s_d;

    logic [PC_W-1:0] stack_top;
    logic stack_push;
    logic stack_pop;
    logic [FILE_ADDR_W-1:0] ind_addr_now;
    logic ind_null_now;
    logic [FILE_ADDR_W-1:0] ind_addr_next;
    logic ind_null_next;
    logic bus_req;
    logic bus_wr_low;

    assign bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack & (s_q.bus == BUS_IDLE);
    assign bus_wr_low = bus_req & wb_we_i & wb_sel_i[0];

    // Push on call or vectoring, pop on a return with no push or jump in the same cycle
    assign stack_push = irq_vector_i | call_i;
    assign stack_pop = ~stack_push & ~jump_i & return_i;

    return_stack u_stack (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(stack_push),
        .pop_i(stack_pop),
        .push_data_i(s_q.pc),
        .top_o(stack_top)
    );

    // Address for the access now in flight
    indirect_addr u_ind_now (
        .file_pointer_i(s_q.fptr),
        .indirect_bank_bit_i(s_q.bank),
        .addr_o(ind_addr_now),
        .null_o(ind_null_now)
    );

    // Address that the sequencer will see next cycle
    indirect_addr u_ind_next (
        .file_pointer_i(s_d.fptr),
        .indirect_bank_bit_i(s_d.bank),
        .addr_o(ind_addr_next),
        .null_o(ind_null_next)
    );

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.file_re = 1'b0;
        s_d.file_we = 1'b0;

        // Counter update, sequencer events ranked by priority
        if (irq_vector_i) begin
            s_d.pc = IRQ_VECTOR;
        end else if (call_i || jump_i) begin
            s_d.pc = branch_target(s_q.latch, s_q.small_mem, target_i);
        end else if (return_i) begin
            s_d.pc = stack_top;
        end else if (pcl_write_i) begin
            s_d.pc = {upper_from_latch(s_q.latch, s_q.small_mem), pcl_wdata_i};
        end else if (bus_wr_low && (wb_adr_i == OFS_PC_LOW_BYTE)) begin
            s_d.pc = {upper_from_latch(s_q.latch, s_q.small_mem), wb_dat_i[7:0]};
        end else if (fetch_i) begin
            s_d.pc = s_q.pc + 13'h0001;
        end

        // Bus slave
        case (s_q.bus)
            BUS_IDLE: begin
                if (bus_req) begin
                    s_d.dat = '0;
                    if (wb_adr_i == OFS_INDIRECT_DATA_PORT) begin
                        // Port has no storage; access goes to the pointed register
                        s_d.file_addr = ind_addr_now;
                        s_d.file_wdata = wb_dat_i[7:0];
                        if (wb_we_i) begin
                            s_d.file_we = wb_sel_i[0] & ~ind_null_now;
                            s_d.ack = 1'b1;
                        end else if (ind_null_now) begin
                            s_d.ack = 1'b1;
                        end else begin
                            s_d.file_re = 1'b1;
                            s_d.bus = BUS_FILE_WAIT;
                        end
                    end else begin
                        s_d.ack = 1'b1;
                        case (wb_adr_i)
                            OFS_PC_LOW_BYTE: begin
                                // Upper bits never appear here
                                s_d.dat[7:0] = s_q.pc[7:0];
                            end
                            OFS_PC_UPPER_LATCH: begin
                                s_d.dat[LATCH_W-1:0] = s_q.latch;
                                if (bus_wr_low) begin
                                    s_d.latch = wb_dat_i[LATCH_W-1:0];
                                end
                            end
                            OFS_FILE_POINTER: begin
                                s_d.dat[7:0] = s_q.fptr;
                                if (bus_wr_low) begin
                                    s_d.fptr = wb_dat_i[7:0];
                                end
                            end
                            OFS_CONTROL: begin
                                s_d.dat[CTRL_BANK_BIT] = s_q.bank;
                                s_d.dat[CTRL_SMALL_MEM_BIT] = s_q.small_mem;
                                if (bus_wr_low) begin
                                    s_d.bank = wb_dat_i[CTRL_BANK_BIT];
                                    s_d.small_mem = wb_dat_i[CTRL_SMALL_MEM_BIT];
                                end
                            end
                            default: begin
                                s_d.dat = '0;
                            end
                        endcase
                    end
                end
            end
            BUS_FILE_WAIT: begin
                s_d.bus = BUS_FILE_TAKE;
            end
            BUS_FILE_TAKE: begin
                s_d.dat = {24'h000000, file_rdata_i};
                s_d.ack = 1'b1;
                s_d.bus = BUS_IDLE;
            end
            default: begin
                s_d.bus = BUS_IDLE;
            end
        endcase

        s_d.ind_addr = ind_addr_next;
        s_d.ind_null = ind_null_next;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.pc <= PC_RESET;
            s_q.latch <= LATCH_RESET;
            s_q.fptr <= FILE_POINTER_RESET;
            s_q.bank <= 1'b0;
            s_q.small_mem <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.dat <= '0;
            s_q.file_addr <= '0;
            s_q.file_re <= 1'b0;
            s_q.file_we <= 1'b0;
            s_q.file_wdata <= 8'h00;
            s_q.ind_addr <= '0;
            s_q.ind_null <= 1'b1;
            s_q.bus <= BUS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign program_counter_o = s_q.pc;
    assign indirect_addr_o = s_q.ind_addr;
    assign indirect_null_o = s_q.ind_null;
    assign file_addr_o = s_q.file_addr;
    assign file_re_o = s_q.file_re;
    assign file_we_o = s_q.file_we;
    assign file_wdata_o = s_q.file_wdata;
    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;

endmodule // program_counter_stack_indirect
`default_nettype wire

// ===== testbench/program_counter_stack_indirect_properties.sv
// Concurrent checks on the ports of the program counter, stack and indirect block
`timescale 1ns/10ps
`default_nettype none
module pc_stack_checker
    import pc_stack_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fetch_i,
    input wire logic call_i,
    input wire logic jump_i,
    input wire logic return_i,
    input wire logic irq_vector_i,
    input wire logic [TARGET_W-1:0] target_i,
    input wire logic pcl_write_i,
    input wire logic [7:0] pcl_wdata_i,
    input wire logic [PC_W-1:0] program_counter_o,
    input wire logic [FILE_ADDR_W-1:0] indirect_addr_o,
    input wire logic indirect_null_o,
    input wire logic [FILE_ADDR_W-1:0] file_addr_o,
    input wire logic file_re_o,
    input wire logic file_we_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [WB_DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_ind;
    logic no_br;
    assign rd_ind = wb_cyc_i && !wb_we_i && wb_adr_i == OFS_INDIRECT_DATA_PORT;
    assign no_br = !(call_i || jump_i || return_i || irq_vector_i);

    a_fetch_step: assert property (
        fetch_i && no_br && !pcl_write_i && !(wb_cyc_i && wb_stb_i)
        |=> program_counter_o == $past(program_counter_o) + 13'h1) else $error("counter did not step");
    a_branch_target: assert property (
        (call_i || jump_i) && !irq_vector_i |=> program_counter_o[10:0] == $past(target_i))
        else $error("branch target wrong");
    a_irq_vector: assert property (
        irq_vector_i |=> program_counter_o == IRQ_VECTOR) else $error("vector wrong");
    a_call_return: assert property (
        (call_i && !irq_vector_i) ##1 (return_i && no_br == 1'b0 && !call_i && !jump_i && !irq_vector_i)
        |=> program_counter_o == $past(program_counter_o, 2)) else $error("return address wrong");
    a_low_write: assert property (
        pcl_write_i && no_br |=> program_counter_o[7:0] == $past(pcl_wdata_i)) else $error("low byte wrong");
    a_null_flag: assert property (
        indirect_null_o == (indirect_addr_o[7:0] == 8'h00)) else $error("null flag wrong");
    a_no_null_write: assert property (
        file_we_o |-> file_addr_o[7:0] != 8'h00) else $error("write through zero pointer");
    a_null_read: assert property (
        $rose(wb_stb_i) && rd_ind && indirect_null_o |=> wb_ack_o && wb_dat_o == '0)
        else $error("zero pointer read not zero");
    a_ind_read_seq: assert property (
        $rose(wb_stb_i) && rd_ind && !indirect_null_o
        |=> file_re_o && file_addr_o == $past(indirect_addr_o) ##1 !wb_ack_o ##1 wb_ack_o)
        else $error("indirect read sequence wrong");
endmodule // pc_stack_checker
bind program_counter_stack_indirect pc_stack_checker u_checker (.*);
`default_nettype wire

// ===== testbench/data_file_model.sv
// Behavioural data register file behind the indirect port
`timescale 1ns/10ps
`default_nettype none
module data_file_model (
    input wire logic clk_i,
    input wire logic [8:0] addr_i,
    input wire logic re_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [512];
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        rdata_o = 8'h00;
    end
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        // Outside a read the data toggles so stale values cannot pass
        rdata_o <= re_i ? mem[addr_i] : ~rdata_o;
    end
endmodule // data_file_model
`default_nettype wire

// ===== testbench/program_counter_stack_indirect_tb.sv
// Self-checking bench for the program counter, stack and indirect block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("Error %s exp %h got %h", nm, e, g); end end
module program_counter_stack_indirect_tb;
    import pc_stack_pkg::*;
    localparam logic [5:0] FETCH = 6'h20, CALL = 6'h10, JUMP = 6'h08, RET = 6'h04, IRQ = 6'h02, PCLW = 6'h01;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fetch_i = 1'b0, call_i = 1'b0, jump_i = 1'b0, return_i = 1'b0, irq_vector_i = 1'b0, pcl_write_i = 1'b0;
    logic [TARGET_W-1:0] target_i = 11'h000;
    logic [7:0] pcl_wdata_i = 8'h00;
    logic [7:0] file_rdata_i, file_wdata_o;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [WB_ADR_W-1:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [WB_DAT_W-1:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, file_re_o, file_we_o, indirect_null_o;
    logic [PC_W-1:0] program_counter_o;
    logic [FILE_ADDR_W-1:0] indirect_addr_o, file_addr_o;
    int fails = 0, samples_checked = 0;
    always #50 clk_i = ~clk_i;
    program_counter_stack_indirect uut (.*);
    data_file_model rf (.clk_i(clk_i), .addr_i(file_addr_o), .re_i(file_re_o), .we_i(file_we_o),
        .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        #1;
    endtask
    task automatic seq(input logic [5:0] op, input logic [10:0] t);
        @(posedge clk_i);
        {fetch_i, call_i, jump_i, return_i, irq_vector_i, pcl_write_i} <= op;
        target_i <= t;
        pcl_wdata_i <= t[7:0];
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        `CHK("null", 1'b1, indirect_null_o)
        for (int a = 0; a < 20; a += 4) begin
            wb(1'b0, 8'(a), 32'h0, rd);
            `CHK("reset reg", 32'h0, rd)
        end
        repeat (3) seq(FETCH, 11'h0);
        seq(6'h0, 11'h0);
        `CHK("pc", 13'h0003, program_counter_o)
        wb(1'b1, OFS_PC_UPPER_LATCH, 32'h15, rd);
        wb(1'b1, OFS_PC_LOW_BYTE, 32'h2c, rd);
        `CHK("pc", 13'h152c, program_counter_o)
        wb(1'b0, OFS_PC_LOW_BYTE, 32'h0, rd);
        `CHK("low byte", 32'h2c, rd)
        wb(1'b0, 8'h40, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        for (int s = 0; s < 2; s++) begin
            wb(1'b1, OFS_CONTROL, 32'(s << 1), rd);
            seq(JUMP, 11'h123);
            seq(6'h0, 11'h0);
            `CHK("jump", {1'(s == 0), 12'h123}, program_counter_o)
            seq(PCLW, 11'h0e7);
            seq(6'h0, 11'h0);
            `CHK("pcl write", {1'(s == 0), 12'h5e7}, program_counter_o)
        end
        // Software moves the latch to the table's block before a computed jump
        wb(1'b1, OFS_PC_UPPER_LATCH, 32'h03, rd);
        seq(PCLW, 11'h0ff);
        seq(FETCH, 11'h0);
        seq(6'h0, 11'h0);
        `CHK("block cross", 13'h0400, program_counter_o)
        wb(1'b1, OFS_PC_UPPER_LATCH, 32'h07, rd);
        wb(1'b1, OFS_CONTROL, 32'h0, rd);
        seq(JUMP, 11'h010);
        for (int k = 1; k < 10; k++) seq(CALL, 11'(11'h100 + k));
        for (int k = 8; k > 0; k--) begin
            seq(RET, 11'h0);
            seq(6'h0, 11'h0);
            `CHK("pop", 13'(13'h100 + k), program_counter_o)
        end
        seq(RET, 11'h0);
        seq(6'h0, 11'h0);
        `CHK("wrap pop", 13'h0108, program_counter_o)
        seq(IRQ, 11'h0);
        seq(6'h0, 11'h0);
        `CHK("vector", IRQ_VECTOR, program_counter_o)
        seq(RET, 11'h0);
        seq(6'h0, 11'h0);
        `CHK("irq return", 13'h0108, program_counter_o)
        wb(1'b0, OFS_PC_UPPER_LATCH, 32'h0, rd);
        `CHK("latch", 32'h07, rd)
        wb(1'b1, OFS_FILE_POINTER, 32'h33, rd);
        wb(1'b1, OFS_CONTROL, 32'h1, rd);
        `CHK("ind addr", 9'h133, indirect_addr_o)
        wb(1'b1, OFS_INDIRECT_DATA_PORT, 32'ha5, rd);
        wb(1'b0, OFS_INDIRECT_DATA_PORT, 32'h0, rd);
        `CHK("ind read", 32'ha5, rd)
        wb(1'b1, OFS_FILE_POINTER, 32'h0, rd);
        wb(1'b1, OFS_INDIRECT_DATA_PORT, 32'h77, rd);
        wb(1'b0, OFS_INDIRECT_DATA_PORT, 32'h0, rd);
        `CHK("null read", 32'h0, rd)
        `CHK("null write", 8'h00, rf.mem[9'h100])
        seq(JUMP, 11'h7ff);
        seq(6'h0, 11'h0);
        `CHK("pre reset", 13'h07ff, program_counter_o)
        // Mid-run reset with nonzero upper counter bits
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        `CHK("pc reset", 13'h0000, program_counter_o)
        seq(FETCH, 11'h0);
        seq(6'h0, 11'h0);
        `CHK("step after reset", 13'h0001, program_counter_o)
        report_and_stop;
    end
endmodule // program_counter_stack_indirect_tb
`default_nettype wire
